// file: inc/jap_pkg.sv
// constants and types shared by the jtag access protection block
package jap_pkg;
  // lock word in boot-loader flash, 0x17FC..0x17FF
  localparam logic [15:0] LOCK_KEY_ADDR = 16'h17FC;
  localparam logic [31:0] KEY_ERASED = 32'h0000_0000;
  localparam logic [31:0] KEY_BLANK = 32'hFFFF_FFFF;
  // fram lock location and signatures
  localparam logic [15:0] FRAM_LOCK_ADDR = 16'hFF80;
  localparam logic [31:0] SECURE_SIG = 32'h5555_5555;
  localparam logic [31:0] FRAM_LOCK_SIG = 32'h5555_5555;
  // mailbox words
  localparam logic [15:0] MB_MODE32 = 16'h0011;
  localparam logic [15:0] MB_MODE16 = 16'h0001;
  localparam logic [15:0] MB_LPM = 16'hA55A;
  localparam logic [15:0] MB_PW_REQ = 16'h1E1E;
  localparam logic [15:0] MB_ERASE = 16'h1A1A;
  localparam int PW_WORDS = 4;
  // protection unit control register
  localparam logic [15:0] PU_CTL_ADDR = 16'h05A0;
  localparam logic [15:0] PU_DISABLE = 16'hA500;
  localparam logic [7:0] PU_KEY = 8'hA5;
  localparam int PU_EN_BIT = 0;
  localparam int PU_LOCK_BIT = 1;
  localparam logic [15:0] PU_CTL_RESET = 16'h0000;
  // instruction codes, 8-bit instruction register
  localparam logic [7:0] IR_BYPASS = 8'hFF;
  localparam logic [7:0] IR_CTL_CAPTURE = 8'h14;
  localparam logic [7:0] IR_CTL_WRITE = 8'h13;
  localparam logic [7:0] IR_MAILBOX = 8'h61;
  localparam logic [7:0] IR_BOR_TRIG = 8'h62;
  localparam logic [7:0] IR_MEM = 8'h63;
  localparam logic [7:0] IR_CAPTURE_VAL = 8'h01;
  // control signal register
  localparam logic [15:0] CTL_RESET = 16'h2401;
  localparam int CTL_POR_BIT = 9;
  // password window
  localparam real PW_TIMEOUT_S = 1.2;
  localparam real CLK_HZ = 200.0e6;
  localparam int PW_TIMEOUT_CYC = int'($floor(PW_TIMEOUT_S * CLK_HZ));

  typedef enum logic [3:0] {
    TAP_TLR = 4'h0, TAP_RTI = 4'h1, TAP_SEL_DR = 4'h3, TAP_CAP_DR = 4'h2,
    TAP_SH_DR = 4'h6, TAP_EX1_DR = 4'h7, TAP_PA_DR = 4'h5,
    TAP_EX2_DR = 4'h4, TAP_UPD_DR = 4'hC, TAP_SEL_IR = 4'hD,
    TAP_CAP_IR = 4'hF, TAP_SH_IR = 4'hE, TAP_EX1_IR = 4'hA,
    TAP_PA_IR = 4'hB, TAP_EX2_IR = 4'h9, TAP_UPD_IR = 4'h8
  } jap_tap_type;
endpackage : jap_pkg

// file: src/jap_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module jap_sync #(
  parameter int W = 4
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
          meta_q[i] <= 1'b0;
          sync_q[i] <= 1'b0;
        end else begin
          meta_q[i] <= async_in[i];
          sync_q[i] <= meta_q[i];
        end
      end
    end
  endgenerate
  assign sync_out = sync_q;
endmodule : jap_sync
`default_nettype wire

// file: src/jap_top.sv
// jtag tap with lock key, secured mode, password mailbox and pu control
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - lock word neither all zeros nor all ones disables jtag on non-fram parts; fram parts ignore it
// - new lock word takes effect only at boot after brownout reset
// - writing the brownout data register resets device and jtag
// - fram secure signature plus brownout refuses all jtag access on password parts
// - protected mode needs matching password before jtag opens
// - locked and reset device offers bypass and mailbox only, one tck delay
// - password window 1.2 s; missing or wrong password forces brownout
// - non-password parts lock on fram lock signature
// - writing 0xA500 to unlocked enabled unit disables it
// - locked protection unit setting clears only by brownout reset
module jap_top
  import jap_pkg::*;
#(
  parameter int PW_TIMEOUT_CYC_P = PW_TIMEOUT_CYC
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic tck_pin,
  input wire logic tms_pin,
  input wire logic tdi_pin,
  input wire logic rst_pin_n,
  output logic tdo_pin,
  output logic tdo_oe,
  input wire logic [31:0] lock_word,
  input wire logic [31:0] fram_word,
  input wire logic is_fram,
  input wire logic has_password,
  input wire logic pw_enable,
  input wire logic [63:0] stored_pw,
  input wire logic fw_pu_we,
  input wire logic [15:0] fw_pu_wdata,
  output logic brownout_reset,
  output logic lpm_request,
  output logic user_erase,
  output logic por_command,
  output logic pu_enable,
  output logic pu_locked,
  output logic jtag_locked
);
  function automatic logic ir_allowed(input logic [7:0] ir,
                                      input logic blk, input logic mb_ok);
    if (ir == IR_BYPASS) return 1'b1;
    if (ir == IR_MAILBOX) return mb_ok;
    return ~blk;
  endfunction : ir_allowed

  function automatic logic [4:0] dr_msb(input logic [7:0] ir);
    unique case (ir)
      IR_MEM: return 5'h1F;
      IR_CTL_CAPTURE, IR_CTL_WRITE, IR_MAILBOX, IR_BOR_TRIG: return 5'h0F;
      default: return 5'h00;
    endcase
  endfunction : dr_msb

  logic s_tck, s_tms, s_tdi, s_rstn;
  jap_sync #(.W(4)) u_sync (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .async_in({tck_pin, tms_pin, tdi_pin, rst_pin_n}),
    .sync_out({s_tck, s_tms, s_tdi, s_rstn})
  );

  jap_tap_type tap_q, tap_d;
  logic [7:0] ir_q, ir_d, irs_q, irs_d, ir_eff;
  logic [31:0] dr_q, dr_d;
  logic tdo_q, tdo_d, oe_q, oe_d, tck_prev_q;
  logic armed_q, armed_d, secured_q, secured_d, prot_q, prot_d;
  logic hp_q, hp_d, unlocked_q, unlocked_d, bypass_q, bypass_d;
  logic [15:0] ctl_q, ctl_d, pu_q, pu_d;
  logic mb_first_q, mb_first_d, mb32_q, mb32_d, pw_wait_q, pw_wait_d;
  logic [1:0] pw_idx_q, pw_idx_d;
  logic [31:0] pw_cnt_q, pw_cnt_d;
  logic bor_q, bor_d, lpmp_q, lpmp_d, lpm_q, lpm_d, erase_q, erase_d;
  logic por_q, por_d, boot_q, rstn_prev_q, locked_q, locked_d;
  logic rise, fall, rst_int, boot_rel, upd_dr, blk, mb_ok, rst_evt;
  logic key_lock, fram_lock;
  logic [15:0] pw_word;

  assign rise = s_tck & ~tck_prev_q;
  assign fall = ~s_tck & tck_prev_q;
  // an internal brownout also resets the tap and lock state
  assign rst_int = sys_rst | bor_q;
  assign boot_rel = boot_q & ~rst_int;
  assign upd_dr = fall & (tap_q == TAP_UPD_DR);
  assign blk = bypass_q | (prot_q & ~unlocked_q);
  // mailbox stays open, except on secured password parts, so locked parts can still be erased or unlocked
  assign mb_ok = ~(secured_q & hp_q);
  assign ir_eff = ir_allowed(ir_q, blk, mb_ok) ? ir_q : IR_BYPASS;
  assign key_lock = (lock_word != KEY_ERASED) && (lock_word != KEY_BLANK);
  assign fram_lock = has_password ? (fram_word == SECURE_SIG)
                                  : (fram_word == FRAM_LOCK_SIG);
  assign pw_word = stored_pw[{pw_idx_q, 4'h0} +: 16];

  // tap state, instruction and data shift
  always_comb begin
    tap_d = tap_q;
    ir_d = ir_q;
    irs_d = irs_q;
    dr_d = dr_q;
    tdo_d = tdo_q;
    oe_d = oe_q;
    if (rise) begin
      unique case (tap_q)
        TAP_TLR: tap_d = s_tms ? TAP_TLR : TAP_RTI;
        TAP_RTI: tap_d = s_tms ? TAP_SEL_DR : TAP_RTI;
        TAP_SEL_DR: tap_d = s_tms ? TAP_SEL_IR : TAP_CAP_DR;
        TAP_CAP_DR: tap_d = s_tms ? TAP_EX1_DR : TAP_SH_DR;
        TAP_SH_DR: tap_d = s_tms ? TAP_EX1_DR : TAP_SH_DR;
        TAP_EX1_DR: tap_d = s_tms ? TAP_UPD_DR : TAP_PA_DR;
        TAP_PA_DR: tap_d = s_tms ? TAP_EX2_DR : TAP_PA_DR;
        TAP_EX2_DR: tap_d = s_tms ? TAP_UPD_DR : TAP_SH_DR;
        TAP_UPD_DR: tap_d = s_tms ? TAP_SEL_DR : TAP_RTI;
        TAP_SEL_IR: tap_d = s_tms ? TAP_TLR : TAP_CAP_IR;
        TAP_CAP_IR: tap_d = s_tms ? TAP_EX1_IR : TAP_SH_IR;
        TAP_SH_IR: tap_d = s_tms ? TAP_EX1_IR : TAP_SH_IR;
        TAP_EX1_IR: tap_d = s_tms ? TAP_UPD_IR : TAP_PA_IR;
        TAP_PA_IR: tap_d = s_tms ? TAP_EX2_IR : TAP_PA_IR;
        TAP_EX2_IR: tap_d = s_tms ? TAP_UPD_IR : TAP_SH_IR;
        TAP_UPD_IR: tap_d = s_tms ? TAP_SEL_DR : TAP_RTI;
      endcase
      if (tap_q == TAP_CAP_DR) begin
        unique case (ir_eff)
          IR_CTL_CAPTURE, IR_CTL_WRITE: dr_d = {16'h0000, ctl_q};
          IR_MEM: dr_d = {PU_CTL_ADDR, pu_q};
          default: dr_d = 32'h0000_0000;
        endcase
      end
      // bypass is a one-bit register, so tdi reappears one tck later
      if (tap_q == TAP_SH_DR) dr_d = {dr_q[30:0], s_tdi};
      if (tap_q == TAP_CAP_IR) irs_d = IR_CAPTURE_VAL;
      if (tap_q == TAP_SH_IR) irs_d = {irs_q[6:0], s_tdi};
    end
    if (fall) begin
      oe_d = (tap_q == TAP_SH_DR) || (tap_q == TAP_SH_IR);
      if (tap_q == TAP_SH_DR) tdo_d = dr_q[dr_msb(ir_eff)];
      if (tap_q == TAP_SH_IR) tdo_d = irs_q[7];
      if (tap_q == TAP_UPD_IR) ir_d = irs_q;
      if (tap_q == TAP_TLR) ir_d = IR_BYPASS;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst_int) begin
      tap_q <= TAP_TLR;
      ir_q <= IR_BYPASS;
      irs_q <= IR_CAPTURE_VAL;
      dr_q <= 32'h0000_0000;
      tdo_q <= 1'b0;
      oe_q <= 1'b0;
      tck_prev_q <= 1'b0;
    end else begin
      tap_q <= tap_d;
      ir_q <= ir_d;
      irs_q <= irs_d;
      dr_q <= dr_d;
      tdo_q <= tdo_d;
      oe_q <= oe_d;
      tck_prev_q <= s_tck;
    end
  end

  // lock state, mailbox and protection unit
  always_comb begin
    armed_d = armed_q;
    secured_d = secured_q;
    prot_d = prot_q;
    hp_d = hp_q;
    unlocked_d = unlocked_q;
    bypass_d = bypass_q;
    ctl_d = ctl_q;
    pu_d = pu_q;
    mb_first_d = mb_first_q;
    mb32_d = mb32_q;
    pw_wait_d = pw_wait_q;
    pw_idx_d = pw_idx_q;
    pw_cnt_d = pw_cnt_q;
    lpmp_d = lpmp_q;
    bor_d = 1'b0;
    erase_d = 1'b0;
    por_d = 1'b0;
    rst_evt = rstn_prev_q & ~s_rstn;
    // lock sampled once per boot, so a fresh key waits for brownout
    if (boot_rel) begin
      armed_d = is_fram ? fram_lock : key_lock;
      secured_d = is_fram & fram_lock;
      hp_d = has_password;
      prot_d = is_fram & has_password & pw_enable;
      unlocked_d = 1'b0;
      bypass_d = is_fram ? fram_lock : key_lock;
    end
    if (fall && tap_q == TAP_UPD_IR && irs_q == IR_MAILBOX) mb_first_d = 1'b1;
    if (upd_dr) begin
      unique case (ir_eff)
        IR_CTL_WRITE: begin
          ctl_d = dr_q[15:0];
          por_d = dr_q[CTL_POR_BIT];
          rst_evt = rst_evt | dr_q[CTL_POR_BIT];
        end
        IR_BOR_TRIG: bor_d = 1'b1;
        IR_MEM: begin
          if (dr_q[31:16] == PU_CTL_ADDR && dr_q[15:8] == PU_KEY &&
              !pu_q[PU_LOCK_BIT]) begin
            pu_d = {8'h00, dr_q[7:0]};
          end
        end
        IR_MAILBOX: begin
          if (mb_first_q) begin
            mb_first_d = 1'b0;
            mb32_d = (dr_q[15:0] == MB_MODE32);
          end else if (pw_wait_q && !mb32_q) begin
            if (dr_q[15:0] != pw_word) begin
              bor_d = 1'b1;
            end else if (pw_idx_q == 2'(PW_WORDS - 1)) begin
              unlocked_d = 1'b1;
              pw_wait_d = 1'b0;
            end else begin
              pw_idx_d = pw_idx_q + 2'h1;
            end
          end else if (dr_q[15:0] == MB_LPM) begin
            lpmp_d = 1'b1;
          end else if (dr_q[15:0] == MB_PW_REQ && prot_q) begin
            pw_wait_d = 1'b1;
            pw_idx_d = 2'h0;
            pw_cnt_d = 32'h0000_0000;
          end else if (dr_q[15:0] == MB_ERASE && !hp_q) begin
            erase_d = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
    if (pw_wait_q) begin
      pw_cnt_d = pw_cnt_q + 32'h0000_0001;
      if (pw_cnt_q == 32'(PW_TIMEOUT_CYC_P - 1)) bor_d = 1'b1;
    end
    if (armed_q && rst_evt) bypass_d = 1'b1;
    // firmware may arm or lock the unit; a locked unit ignores all writes
    if (fw_pu_we && !pu_q[PU_LOCK_BIT]) pu_d = {8'h00, fw_pu_wdata[7:0]};
    lpm_d = lpmp_q & s_rstn;
    locked_d = blk;
  end

  always_ff @(posedge clk_sys) begin
    if (rst_int) begin
      armed_q <= 1'b0;
      secured_q <= 1'b0;
      prot_q <= 1'b0;
      hp_q <= 1'b0;
      unlocked_q <= 1'b0;
      bypass_q <= 1'b0;
      ctl_q <= CTL_RESET;
      pu_q <= PU_CTL_RESET;
      mb_first_q <= 1'b0;
      mb32_q <= 1'b0;
      pw_wait_q <= 1'b0;
      pw_idx_q <= 2'h0;
      pw_cnt_q <= 32'h0000_0000;
      erase_q <= 1'b0;
      por_q <= 1'b0;
      locked_q <= 1'b0;
    end else begin
      armed_q <= armed_d;
      secured_q <= secured_d;
      prot_q <= prot_d;
      hp_q <= hp_d;
      unlocked_q <= unlocked_d;
      bypass_q <= bypass_d;
      ctl_q <= ctl_d;
      pu_q <= pu_d;
      mb_first_q <= mb_first_d;
      mb32_q <= mb32_d;
      pw_wait_q <= pw_wait_d;
      pw_idx_q <= pw_idx_d;
      pw_cnt_q <= pw_cnt_d;
      erase_q <= erase_d;
      por_q <= por_d;
      locked_q <= locked_d;
    end
  end

  // low-power request must survive the brownout it precedes
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      bor_q <= 1'b0;
      boot_q <= 1'b1;
      lpmp_q <= 1'b0;
      lpm_q <= 1'b0;
      // synchroniser resets low; a high start would fake a reset-pin edge
      rstn_prev_q <= 1'b0;
    end else begin
      bor_q <= bor_d & ~bor_q;
      boot_q <= rst_int;
      lpmp_q <= lpmp_d;
      lpm_q <= lpm_d;
      rstn_prev_q <= s_rstn;
    end
  end

  assign tdo_pin = tdo_q;
  assign tdo_oe = oe_q;
  assign brownout_reset = bor_q;
  assign lpm_request = lpm_q;
  assign user_erase = erase_q;
  assign por_command = por_q;
  assign pu_enable = pu_q[PU_EN_BIT];
  assign pu_locked = pu_q[PU_LOCK_BIT];
  assign jtag_locked = locked_q;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  property p_key_lock;
    boot_rel && !is_fram && key_lock |=> armed_q && bypass_q;
  endproperty
  a_key_lock: assert property (p_key_lock) else $error("key lock not armed");

  property p_boot_only;
    !boot_rel && !rst_int |=> $stable(armed_q);
  endproperty
  a_boot_only: assert property (p_boot_only) else $error("lock armed late");

  property p_bor_trig;
    upd_dr && ir_eff == IR_BOR_TRIG |=> brownout_reset ##1 tap_q == TAP_TLR;
  endproperty
  a_bor_trig: assert property (p_bor_trig) else $error("no brownout");

  property p_secure;
    boot_rel && is_fram && fram_lock |=> bypass_q ##1 jtag_locked;
  endproperty
  a_secure: assert property (p_secure) else $error("secure not set");

  property p_pw_gate;
    prot_q && !unlocked_q && ir_q != IR_MAILBOX |-> ir_eff == IR_BYPASS;
  endproperty
  a_pw_gate: assert property (p_pw_gate) else $error("pw gate open");

  property p_bypass_only;
    bypass_q |-> ir_eff == IR_BYPASS || ir_eff == IR_MAILBOX;
  endproperty
  a_bypass_only: assert property (p_bypass_only) else $error("not bypass");

  property p_pw_timeout;
    pw_wait_q && pw_cnt_q == 32'(PW_TIMEOUT_CYC_P - 1) |=> brownout_reset;
  endproperty
  a_pw_timeout: assert property (p_pw_timeout) else $error("no timeout");

  property p_pu_disable;
    upd_dr && ir_eff == IR_MEM && dr_q == {PU_CTL_ADDR, PU_DISABLE} &&
    !pu_q[PU_LOCK_BIT] && !fw_pu_we |=> !pu_enable && !pu_locked;
  endproperty
  a_pu_disable: assert property (p_pu_disable) else $error("pu enabled");

  property p_pu_lock;
    pu_locked && !rst_int |=> pu_locked && $stable(pu_q);
  endproperty
  a_pu_lock: assert property (p_pu_lock) else $error("pu lock lost");
endmodule : jap_top
`default_nettype wire

// file: tb/jap_host.sv
// jtag host programmer model driving the test port pins
`timescale 1ns/1ps
`default_nettype none
module jap_host (
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  // one 80 ns tck period; tck rests low between frames
  task automatic cyc(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #40;
    q = tdo;
    tck = 1'b1;
    #40;
    tck = 1'b0;
  endtask : cyc

  // tdi toggles outside shifts so a stale bit is never mistaken for data
  task automatic idle(input logic m);
    logic q;
    cyc(m, ~tdi, q);
  endtask : idle

  task automatic tap_reset();
    #1.3;
    repeat (5) idle(1'b1);
    idle(1'b0);
  endtask : tap_reset

  // from run-test/idle, msb first, ends back in run-test/idle
  task automatic shift(input logic ir_sel, input int n,
      input logic [31:0] din, output logic [31:0] dout);
    logic q;
    dout = '0;
    idle(1'b1);
    if (ir_sel) idle(1'b1);
    idle(1'b0);
    idle(1'b0);
    for (int i = n - 1; i >= 0; i--) begin
      cyc(i == 0, din[i], q);
      dout = {dout[30:0], q};
    end
    idle(1'b1);
    idle(1'b0);
  endtask : shift
endmodule : jap_host
`default_nettype wire

// file: tb/tb_top.sv
// self-checking bench for the jtag access protection block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import jap_pkg::*;
  // shortened password window so a timeout fits in the run
  localparam int TO = 4000;
  logic clk_sys = 1'b0;
  logic sys_rst, tck, tms, tdi, rst_pin_n, tdo_pin, tdo_oe, is_fram;
  logic has_password, pw_enable, fw_pu_we, brownout_reset, lpm_request;
  logic user_erase, por_command, pu_enable, pu_locked, jtag_locked;
  logic [31:0] lock_word, fram_word, q;
  logic [31:0] lws [6];
  logic [63:0] stored_pw;
  logic [15:0] fw_pu_wdata;
  logic e, bootloader_write_protect;
  int fails = 0;
  int comparisons = 0;
  int bors = 0;
  int erases = 0;
  int pors = 0;
  int n0;

  always #2.5 clk_sys = ~clk_sys;
  // pulses are counted mid-cycle, away from the edge that launches them
  always @(negedge clk_sys) begin
    if (brownout_reset === 1'b1) bors++;
    if (user_erase === 1'b1) erases++;
    if (por_command === 1'b1) pors++;
  end

  jap_top #(.PW_TIMEOUT_CYC_P(TO)) i_dut (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .tck_pin(tck), .tms_pin(tms), .tdi_pin(tdi),
    .rst_pin_n(rst_pin_n), .tdo_pin(tdo_pin), .tdo_oe(tdo_oe),
    .lock_word(lock_word), .fram_word(fram_word), .is_fram(is_fram),
    .has_password(has_password), .pw_enable(pw_enable),
    .stored_pw(stored_pw), .fw_pu_we(fw_pu_we), .fw_pu_wdata(fw_pu_wdata),
    .brownout_reset(brownout_reset), .lpm_request(lpm_request),
    .user_erase(user_erase), .por_command(por_command),
    .pu_enable(pu_enable), .pu_locked(pu_locked),
    .jtag_locked(jtag_locked));
  jap_host i_host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_pin));

  function automatic logic exp_lock(input logic [31:0] lw, fw,
      input logic f, hp, pe);
    if (f) return fw == SECURE_SIG || (hp && pe);
    return lw != KEY_ERASED && lw != KEY_BLANK;
  endfunction : exp_lock

  task automatic close_out();
    $display("checks %0d mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t word %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chkf(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t flag %b expected %b", $time, got, exp);
    end
  endtask : chkf

  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : tick

  task automatic ir(input logic [7:0] c);
    logic [31:0] r;
    i_host.tap_reset();
    i_host.shift(1'b1, 8, {24'h0, c}, r);
  endtask : ir

  task automatic dr(input int n, input logic [31:0] d);
    i_host.shift(1'b0, n, d, q);
  endtask : dr

  task automatic boot(input logic [31:0] lw, fw, input logic f, hp, pe);
    tick(1);
    lock_word = lw;
    fram_word = fw;
    is_fram = f;
    has_password = hp;
    pw_enable = pe;
    sys_rst = 1'b1;
    tick(4);
    sys_rst = 1'b0;
    tick(4);
  endtask : boot

  task automatic probe();
    ir(IR_CTL_CAPTURE);
    dr(16, 32'hAAAA);
    tick(2);
  endtask : probe

  task automatic mbox3(input logic [15:0] a, b, c);
    ir(IR_MAILBOX);
    dr(16, a);
    dr(16, b);
    dr(16, c);
  endtask : mbox3

  task automatic bortrig();
    ir(IR_BOR_TRIG);
    dr(16, 32'h0);
    tick(20);
  endtask : bortrig

  task automatic mem(input logic [15:0] d);
    ir(IR_MEM);
    dr(32, {PU_CTL_ADDR, d});
    tick(10);
  endtask : mem

  task automatic pw_request();
    tick(1);
    rst_pin_n = 1'b0;
    mbox3(MB_MODE32, MB_LPM, MB_PW_REQ);
    tick(1);
    rst_pin_n = 1'b1;
    tick(20);
  endtask : pw_request

  initial begin
    #400us;
    fails++;
    close_out();
  end

  initial begin
    {sys_rst, rst_pin_n, fw_pu_we, is_fram} = 4'b1100;
    {has_password, pw_enable, lock_word, fram_word} = '0;
    {stored_pw, fw_pu_wdata} = '0;
    bootloader_write_protect = 1'b1;
    n0 = $urandom(8);
    tick(20);
    sys_rst = 1'b0;
    lws = '{KEY_ERASED, KEY_BLANK, 32'h1, 32'hFFFF_FFFE, $urandom(),
      $urandom()};
    foreach (lws[i]) begin
      boot(lws[i], 32'h0, 1'b0, 1'b0, 1'b0);
      e = exp_lock(lws[i], 32'h0, 1'b0, 1'b0, 1'b0);
      probe();
      chk(q[15:0], e ? 32'h5555 : {16'h0, CTL_RESET});
      chkf(jtag_locked, e);
      chkf(tdo_oe, 1'b0);
    end
    // a key written at run time waits for the next brownout
    boot(KEY_BLANK, 32'h0, 1'b0, 1'b0, 1'b0);
    // boot-loader flash only takes the key once its protection is off
    bootloader_write_protect = 1'b0;
    if (!bootloader_write_protect)
      lock_word = ($urandom() & 32'h7FFF_FFFF) | 32'h10;
    probe();
    chk(q[15:0], {16'h0, CTL_RESET});
    n0 = bors;
    bortrig();
    chk(bors - n0, 1);
    chkf(jtag_locked, 1'b1);
    probe();
    chk(q[15:0], 32'h5555);
    for (int hp = 0; hp < 2; hp++) begin
      boot(KEY_BLANK, SECURE_SIG, 1'b1, hp[0], 1'b0);
      chkf(jtag_locked, 1'b1);
      n0 = erases;
      tick(1);
      rst_pin_n = 1'b0;
      mbox3(MB_MODE16, MB_LPM, MB_ERASE);
      tick(10);
      chk(erases - n0, hp ? 0 : 1);
      chkf(lpm_request, 1'b0);
      rst_pin_n = 1'b1;
      tick(10);
      chkf(lpm_request, !hp);
    end
    // an unlocked part accepts a control register write that issues a por command
    boot(KEY_BLANK, 32'h0, 1'b0, 1'b0, 1'b0);
    n0 = pors;
    ir(IR_CTL_WRITE);
    dr(16, {16'h0, CTL_RESET | 16'h0200});
    tick(10);
    chk(pors - n0, 1);
    chkf(jtag_locked, 1'b0);
    stored_pw = {$urandom(), $urandom()};
    boot(KEY_BLANK, 32'h0, 1'b1, 1'b1, 1'b1);
    chkf(jtag_locked, 1'b1);
    n0 = bors;
    pw_request();
    ir(IR_MAILBOX);
    dr(16, MB_MODE16);
    for (int i = 0; i < PW_WORDS; i++)
      dr(16, stored_pw[16*i +: 16] ^ (i == 3 ? 16'h0100 : 16'h0));
    tick(10);
    chk(bors - n0, 1);
    pw_request();
    tick(TO + 50);
    chk(bors - n0, 2);
    pw_request();
    ir(IR_MAILBOX);
    dr(16, MB_MODE16);
    for (int i = 0; i < PW_WORDS; i++)
      dr(16, stored_pw[16*i +: 16]);
    tick(TO + 50);
    chk(bors - n0, 2);
    chkf(jtag_locked, 1'b0);
    probe();
    chk(q[15:0], {16'h0, CTL_RESET});
    // the unit takes only keyed jtag writes, and once locked clears only on brownout
    boot(KEY_BLANK, 32'h0, 1'b0, 1'b0, 1'b0);
    mem(16'hA501);
    chkf(pu_enable, 1'b1);
    mem(16'h5A00);
    chk(q, {PU_CTL_ADDR, 16'h0001});
    chkf(pu_enable, 1'b1);
    mem(PU_DISABLE);
    chkf(pu_enable, 1'b0);
    fw_pu_we = 1'b1;
    fw_pu_wdata = 16'h0003;
    tick(1);
    fw_pu_we = 1'b0;
    tick(2);
    chkf(pu_locked, 1'b1);
    mem(PU_DISABLE);
    chkf(pu_enable, 1'b1);
    bortrig();
    chk({pu_locked, pu_enable}, 32'h0);
    close_out();
  end
endmodule : tb_top
`default_nettype wire
